/* File: rtl/abc_pkg.sv */
// abc_pkg: shared constants and types for the converter bus control block
package abc_pkg;
   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_START_NS = 300;      // all three controls low before start
   localparam int T_DELAY_CONV_NS = 700; // longest delay to conversion start
   localparam int T_ACCESS_NS = 250;     // longest bus access time
   localparam int T_HOLD_NS = 25;        // least data hold after select rise
   localparam int T_FLOAT_NS = 150;      // longest output float delay
   localparam int T_CONV_US = 10;        // longest conversion time
   localparam int T_RW_LOW_NS = 10250;   // least read-not-write low, continuous
   // least times round up, longest round down
   localparam int START_CYC = (T_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_CYC = (T_CONV_US * 1000) / CLK_PERIOD_NS;
   localparam int RW_LOW_CYC = (T_RW_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
   localparam logic [CNT_W-1:0] START_CNT = CNT_W'(START_CYC);
   localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(HOLD_CYC);
   localparam logic [CNT_W-1:0] CONV_CNT = CNT_W'(CONV_CYC);
   localparam logic [CNT_W-1:0] RW_LOW_CNT = CNT_W'(RW_LOW_CYC);
   // ************************************************************
   // data
   // ************************************************************
   localparam int DATA_W = 8;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] SIGN_BIT = 8'h80;
   typedef logic [DATA_W-1:0] abc_data_t;
endpackage : abc_pkg

/* File: rtl/abc_bus_if.sv */
// abc_bus_if: control pins, busy status and the shared three-state data bus
`timescale 1ns/100ps
interface abc_bus_if;
   import abc_pkg::*;
   logic chipSelN;
   logic chipEnN;
   logic readNotWrite;
   logic polaritySelect;
   logic codingSelect;
   logic busyStatus;
   abc_data_t dataOut;
   logic dataOe;
   abc_data_t dataBus;
   // bus level worked out from the device enable; floats read as zero here
   assign dataBus = dataOe ? dataOut : DATA_ZERO;
   modport device (
      input chipSelN, chipEnN, readNotWrite, polaritySelect, codingSelect,
      output busyStatus, dataOut, dataOe
   );
   modport master (
      output chipSelN, chipEnN, readNotWrite, polaritySelect, codingSelect,
      input busyStatus, dataBus, dataOe
   );
endinterface : abc_bus_if

/* File: rtl/abc_device.sv */
// abc_device: converter control and timing end, driving busy and data bus
// Behaviour
// [R1] both selects interchangeable, both low needed
// [R2] master holds select low 300 ns
// [R3] read-not-write low converts, high reads
// [R4] busy rises after 300 ns all low
// [R5] conversion begins within 700 ns
// [R6] starts ignored while busy
// [R7] drivers off during conversion
// [R8] data floats outside read cycles
// [R9] read data valid within 250 ns
// [R10] select rise: hold 25 ns, float 150
// [R11] result readable 250 ns after busy falls
// [R12] stand-alone: selects tied, low rw starts
// [R13] single mode: rw returns high after start
// [R14] single mode: result held until ends
// [R15] continuous: back to back, busy pulses
// [R16] rw rise: one final conversion, present
// [R17] master raises rw only while busy
// [R18] continuous rw low at least 10.25 us
// [R19] final result held; rw fall restarts
// [R20] busy high during each conversion
// [R21] master sets polarity, coding before start
// [R22] fixed-length count, result updates at end
`timescale 1ns/100ps
module abc_device (
   input wire logic ref_clk,
   input wire logic reset,
   abc_bus_if.device bus,
   input wire abc_pkg::abc_data_t sampleValue,
   output logic convDone
);
   import abc_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef enum logic [1:0] {
      ABC_IDLE = 2'b00,
      ABC_CONV = 2'b01,
      ABC_REST = 2'b11
   } abc_state_e;

   typedef struct packed {
      logic [2:0] csSync;
      logic [2:0] ceSync;
      logic [2:0] rwSync;
      logic csN;
      logic ceN;
      logic rw;
      abc_state_e state;
      logic [CNT_W-1:0] lowCnt;
      logic [CNT_W-1:0] convCnt;
      logic [CNT_W-1:0] holdCnt;
      logic pol;
      logic fmt;
      abc_data_t result;
      logic busy;
      logic oe;
      logic done;
   } abc_dev_s;

   abc_dev_s st_reg;
   abc_dev_s st_next;
   logic selLow;
   logic startReq;
   logic readReq;

   // control decode on the filtered pin levels
   assign selLow = !st_reg.csN && !st_reg.ceN;          // [R1]
   assign startReq = selLow && !st_reg.rw;              // [R3]
   assign readReq = selLow && st_reg.rw;                // [R3]

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      // three-flop synchronisers; a change counts once the last two agree
      st_next.csSync = {st_reg.csSync[1:0], bus.chipSelN};
      st_next.ceSync = {st_reg.ceSync[1:0], bus.chipEnN};
      st_next.rwSync = {st_reg.rwSync[1:0], bus.readNotWrite};
      if (st_reg.csSync[2] == st_reg.csSync[1]) st_next.csN = st_reg.csSync[2];
      if (st_reg.ceSync[2] == st_reg.ceSync[1]) st_next.ceN = st_reg.ceSync[2];
      if (st_reg.rwSync[2] == st_reg.rwSync[1]) st_next.rw = st_reg.rwSync[2];
      // qualify the start: all three low for the full pulse width
      if (startReq) begin
         if (st_reg.lowCnt != START_CNT) st_next.lowCnt = st_reg.lowCnt + CNT_ONE; // [R4]
      end else begin
         st_next.lowCnt = CNT_ZERO;
      end
      case (st_reg.state)
         ABC_IDLE: begin
            // begins within a few cycles, far inside 700 ns
            if (startReq && st_reg.lowCnt == START_CNT) begin // [R4] [R5]
               st_next.state = ABC_CONV;
               st_next.busy = 1'b1;                        // [R20]
               st_next.convCnt = CNT_ZERO;
               st_next.pol = bus.polaritySelect;           // [R21]
               st_next.fmt = bus.codingSelect;
            end
         end
         ABC_CONV: begin
            // further starts have no effect until the count ends
            st_next.convCnt = st_reg.convCnt + CNT_ONE;    // [R6]
            if (st_reg.convCnt == CONV_CNT - CNT_ONE) begin // [R22]
               st_next.result = st_reg.fmt ? (sampleValue ^ SIGN_BIT) : sampleValue;
               st_next.busy = 1'b0;                        // [R20] [R15]
               st_next.done = 1'b1;
               st_next.state = ABC_REST;
            end
         end
         ABC_REST: begin
            // one-cycle reset gap; continuous mode rearms while rw stays low
            st_next.state = ABC_IDLE;                      // [R15] [R16] [R17]
         end
         default: st_next.state = ABC_IDLE;
      endcase
      // output drive: only in read, never while busy, held then float
      if (readReq && !st_reg.busy && st_next.state != ABC_CONV) begin // [R7] [R9] [R11]
         st_next.oe = 1'b1;                                // [R14] [R19]
         st_next.holdCnt = HOLD_CNT;
      end else if (st_reg.oe && st_reg.holdCnt != CNT_ZERO && !st_reg.busy
                   && !startReq) begin
         st_next.holdCnt = st_reg.holdCnt - CNT_ONE;       // [R10]
      end else begin
         st_next.oe = 1'b0;                                // [R8] [R10]
         st_next.holdCnt = CNT_ZERO;
      end
      if (st_next.state == ABC_CONV) st_next.oe = 1'b0;   // [R7]
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_reg <= '{csSync: 3'h7, ceSync: 3'h7, rwSync: 3'h7, csN: 1'b1, ceN: 1'b1,
                     rw: 1'b1, state: ABC_IDLE, lowCnt: CNT_ZERO, convCnt: CNT_ZERO,
                     holdCnt: CNT_ZERO, pol: 1'b0, fmt: 1'b0, result: DATA_ZERO,
                     busy: 1'b0, oe: 1'b0, done: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign bus.busyStatus = st_reg.busy;
   assign bus.dataOut = st_reg.result;
   assign bus.dataOe = st_reg.oe;
   assign convDone = st_reg.done;
endmodule : abc_device

/* File: rtl/abc_master.sv */
// abc_master: bus master end that starts conversions and reads results
`timescale 1ns/100ps
module abc_master (
   input wire logic ref_clk,
   input wire logic reset,
   abc_bus_if.master bus,
   input wire logic convReq,
   input wire logic readReq,
   input wire logic contMode,
   input wire logic polarityIn,
   input wire logic codingIn,
   output logic reqReady,
   output abc_pkg::abc_data_t readData,
   output logic readValid
);
   import abc_pkg::*;

   // continuous series: hold rw low past one whole conversion so that the
   // rise lands inside the second one and the series runs back to back
   localparam logic [CNT_W-1:0] CONT_CNT = RW_LOW_CNT + CONV_CNT;

   typedef enum logic [2:0] {
      ABM_IDLE = 3'b000,
      ABM_WRITE = 3'b001,
      ABM_WAIT = 3'b011,
      ABM_READ = 3'b010,
      ABM_LEAVE = 3'b110
   } abm_state_e;

   typedef struct packed {
      abm_state_e state;
      logic [CNT_W-1:0] cnt;
      logic selN;
      logic rw;
      logic pol;
      logic fmt;
      logic cont;
      logic [2:0] busySync;
      logic busy;
      abc_data_t data;
      logic valid;
   } abm_s;

   abm_s st_reg;
   abm_s st_next;

   // ************************************************************
   // sequencer
   // ************************************************************
   always_comb begin
      st_next = st_reg;
      st_next.valid = 1'b0;
      st_next.busySync = {st_reg.busySync[1:0], bus.busyStatus};
      if (st_reg.busySync[2] == st_reg.busySync[1]) st_next.busy = st_reg.busySync[2];
      st_next.cnt = st_reg.cnt + CNT_ONE;
      case (st_reg.state)
         ABM_IDLE: begin
            st_next.cnt = CNT_ZERO;
            if (convReq) begin
               // coding inputs set in the same cycle as the selects fall
               st_next.pol = polarityIn;                   // [R21]
               st_next.fmt = codingIn;
               st_next.cont = contMode;
               st_next.rw = 1'b0;                          // [R12]
               st_next.selN = 1'b0;
               st_next.state = ABM_WRITE;
            end else if (readReq) begin
               st_next.rw = 1'b1;
               st_next.selN = 1'b0;
               st_next.state = ABM_READ;
            end
         end
         ABM_WRITE: begin
            // hold rw low until the device is busy and the low time is met
            if (st_reg.busy && st_reg.cnt >= START_CNT
                && (!st_reg.cont || st_reg.cnt >= CONT_CNT)) begin // [R2] [R18] [R17]
               st_next.rw = 1'b1;                          // [R13] [R16]
               st_next.state = ABM_WAIT;
            end
         end
         ABM_WAIT: begin
            if (!st_reg.busy) begin
               st_next.cnt = CNT_ZERO;
               st_next.state = ABM_READ;
            end
         end
         ABM_READ: begin
            // sample once access time has safely passed
            if (!st_reg.busy && st_reg.cnt >= START_CNT && bus.dataOe) begin
               st_next.data = bus.dataBus;
               st_next.valid = 1'b1;
               st_next.selN = 1'b1;
               st_next.cnt = CNT_ZERO;
               st_next.state = ABM_LEAVE;
            end
         end
         ABM_LEAVE: begin
            // let the outputs float before another request
            if (st_reg.cnt >= START_CNT) st_next.state = ABM_IDLE;
         end
         default: st_next.state = ABM_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_reg <= '{state: ABM_IDLE, cnt: CNT_ZERO, selN: 1'b1, rw: 1'b1, pol: 1'b0,
                     fmt: 1'b0, cont: 1'b0, busySync: 3'h0, busy: 1'b0,
                     data: DATA_ZERO, valid: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   // selects tied together in stand-alone use
   assign bus.chipSelN = st_reg.selN;
   assign bus.chipEnN = st_reg.selN;
   assign bus.readNotWrite = st_reg.rw;
   assign bus.polaritySelect = st_reg.pol;
   assign bus.codingSelect = st_reg.fmt;
   assign reqReady = (st_reg.state == ABM_IDLE);
   assign readData = st_reg.data;
   assign readValid = st_reg.valid;
endmodule : abc_master

/* File: verification/abc_checker.sv */
// abc_checker: timing assertions on the converter bus pins
`timescale 1ns/100ps
module abc_checker (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic chipSelN,
   input wire logic chipEnN,
   input wire logic readNotWrite,
   input wire logic busyStatus,
   input wire abc_pkg::abc_data_t dataOut,
   input wire logic dataOe
);
   import abc_pkg::*;
   logic allLow, rdCond, selHigh;
   logic [11:0] lowCnt_reg, busyLen_reg;
   assign allLow = !chipSelN && !chipEnN && !readNotWrite;
   assign rdCond = !chipSelN && !chipEnN && readNotWrite;
   assign selHigh = chipSelN || chipEnN;
   // run lengths; 12 bits wrap only after far longer holds than any test uses
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         lowCnt_reg <= 12'h000;
         busyLen_reg <= 12'h000;
      end else begin
         lowCnt_reg <= allLow ? lowCnt_reg + 12'h001 : 12'h000;
         busyLen_reg <= busyStatus ? busyLen_reg + 12'h001 : 12'h000;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // ************************************************************
   // properties
   // ************************************************************
   property p_offBusy; busyStatus |-> !dataOe; endproperty
   a_offBusy: assert property (p_offBusy) else $error("bus driven in conversion");
   property p_float; (selHigh || !readNotWrite) [*8] |=> !dataOe; endproperty
   a_float: assert property (p_float) else $error("bus driven outside read");
   property p_hold; $rose(selHigh) && dataOe |-> (dataOe && $stable(dataOut)) [*2]; endproperty
   a_hold: assert property (p_hold) else $error("data not held");
   property p_end; $rose(selHigh) && dataOe |-> ##[1:15] !dataOe; endproperty
   a_end: assert property (p_end) else $error("bus not floated");
   property p_start; $rose(busyStatus) |-> lowCnt_reg >= 12'd30; endproperty
   a_start: assert property (p_start) else $error("busy without start");
   property p_begin; lowCnt_reg == 12'd30 && !busyStatus |-> ##[0:70] busyStatus; endproperty
   a_begin: assert property (p_begin) else $error("conversion late");
   property p_len;
      $fell(busyStatus) && !$past(reset) |-> busyLen_reg <= CONV_CNT && busyLen_reg > 12'd990;
   endproperty
   a_len: assert property (p_len) else $error("busy length wrong");
   property p_access; $rose(rdCond) && !busyStatus |-> ##[1:25] (dataOe || !rdCond); endproperty
   a_access: assert property (p_access) else $error("read access late");
   property p_ready;
      $fell(busyStatus) && rdCond && !$past(reset) |-> ##[1:25] (dataOe || !rdCond);
   endproperty
   a_ready: assert property (p_ready) else $error("result late after busy");
   property p_steady; dataOe && $past(dataOe) |-> $stable(dataOut); endproperty
   a_steady: assert property (p_steady) else $error("data moved while driven");
endmodule : abc_checker

/* File: verification/adc_bus_control_timing_tb.sv */
// adc_bus_control_timing_tb: both ends joined, conversions and reads checked
`timescale 1ns/100ps
module adc_bus_control_timing_tb;
   import abc_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic convReq = 1'b0;
   logic readReq = 1'b0;
   logic contMode = 1'b0;
   logic polarityIn = 1'b0;
   logic codingIn = 1'b0;
   logic reqReady, readValid, convDone, busyOld;
   abc_data_t sampleValue = DATA_ZERO;
   abc_data_t readData, expVal;
   abc_data_t expQ[$];
   abc_data_t vals[4];
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   int dones = 0;
   int rises = 0;
   abc_bus_if abc_bus_if_inst ();
   abc_device abc_device_inst (.ref_clk(ref_clk), .reset(reset), .bus(abc_bus_if_inst),
      .sampleValue(sampleValue), .convDone(convDone));
   abc_master abc_master_inst (.ref_clk(ref_clk), .reset(reset), .bus(abc_bus_if_inst),
      .convReq(convReq), .readReq(readReq), .contMode(contMode), .polarityIn(polarityIn),
      .codingIn(codingIn), .reqReady(reqReady), .readData(readData), .readValid(readValid));
   abc_checker abc_checker_inst (.ref_clk(ref_clk), .reset(reset),
      .chipSelN(abc_bus_if_inst.chipSelN), .chipEnN(abc_bus_if_inst.chipEnN),
      .readNotWrite(abc_bus_if_inst.readNotWrite), .busyStatus(abc_bus_if_inst.busyStatus),
      .dataOut(abc_bus_if_inst.dataOut), .dataOe(abc_bus_if_inst.dataOe));
   initial forever #5 ref_clk = ~ref_clk;
   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic wait_ready();
      for (int n = 0; n < 5000 && reqReady !== 1'b1; n++) tick();
   endtask : wait_ready
   // one convert (two in continuous mode) then read; the expected word is noted when the start is issued
   task automatic run_one(input logic cont, input logic [1:0] mode, input abc_data_t val);
      int target;
      wait_ready();
      target = dones + (cont ? 2 : 1);
      sampleValue = val;
      codingIn = mode[0];
      polarityIn = mode[1];
      contMode = cont;
      convReq = 1'b1;
      expQ.push_back(val ^ (mode[0] ? SIGN_BIT : DATA_ZERO));
      tick();
      convReq = 1'b0;
      for (int n = 0; n < 6000 && dones < target; n++) tick();
      wait_ready();
      if (expQ.size() > 0) begin
         readReq = 1'b1;
         tick();
         readReq = 1'b0;
      end
      for (int n = 0; n < 300 && expQ.size() > 0; n++) tick();
   endtask : run_one
   // watcher: takes the oldest note at each result, counts conversions, cuts hangs
   always @(posedge ref_clk) begin
      cycles++;
      if (convDone === 1'b1) dones++;
      if (abc_bus_if_inst.busyStatus === 1'b1 && busyOld !== 1'b1) rises++;
      busyOld = abc_bus_if_inst.busyStatus;
      if (readValid === 1'b1) begin
         expVal = 8'hxx;
         if (expQ.size() > 0) expVal = expQ.pop_front();
         check("readData", expVal, readData);
      end
      if (cycles == 20000) begin
         miscompares++;
         report_and_stop();
      end
   end
   initial begin
      void'($urandom(50753));
      vals = '{8'h00, 8'hff, 8'h80, 8'($urandom)};
      repeat (16) @(posedge ref_clk);
      #1 reset = 1'b0;
      // every coding and polarity setting, boundary words, back to back
      foreach (vals[i]) run_one(1'b0, 2'(i), vals[i]);
      run_one(1'b1, 2'($urandom), 8'($urandom));
      repeat (20) tick();
      check("conversions", 8'(rises), 8'(dones));
      check("series", 8'h01, 8'(dones >= 6));
      check("dataOe idle", 8'h00, 8'(abc_bus_if_inst.dataOe));
      report_and_stop();
   end
endmodule : adc_bus_control_timing_tb
